// File: rtl/lldcp_core.sv
// Purpose: Device-side command decode, latency timing and data path of a
//          low-latency DRAM synchronous interface, with a small array.
// Assumes: All pins arrive asynchronous to clock and are sampled by it.
// Notes:   Input clock and write data clock edges are found by sampling.
// Functional notes
// - Multiplexed mode sends the address in two halves over eleven lines.
// - Bank refresh needs no second address cycle; may repeat every clock.
// - Device rebuilds the full address from both halves per width and burst.
// - With termination on, data lines and write mask are terminated only.
// - Data termination turns off while read data is driven, back on after.
// - Write mask stays terminated whenever termination is enabled.
// - Idle command starts nothing; registered operations still complete.
// - Read is select low with write strobe and refresh strobe high.
// - Read data appears read latency cycles after the read command.
// - Read data edge-aligned to a free-running read data clock.
// - Read-valid rises half a cycle before the first read data item.
// - Read-valid falls together with the final item of the burst.
// - Data lines released when no further read follows the burst.
// - Read-valid holds high while the input clock stops mid-burst.
// - Back-to-back reads give a gapless data stream.
// - Write is select and write strobe low with refresh strobe high.
// - Write data taken write latency later, read latency plus one.
// - Items with write mask high are not stored.
// - Write data and mask are sampled on the write data clock.
// - Multiplexed mode adds one cycle to both latencies.

`timescale 1ns/100ps
`default_nettype none

module lldcp_core
   import lldcp_pkg::*;
(
   // System clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Command and address pins
   input  wire logic                in_clk,
   input  wire logic                sel_n,
   input  wire logic                wr_strobe_n,
   input  wire logic                ref_strobe_n,
   input  wire logic [BANK_W-1:0]   bank_addr,
   input  wire logic [ADDR_W-1:0]   addr,
   // Data pins
   input  wire logic                write_data_clk,
   input  wire logic [DATA_W-1:0]   dq_in,
   output logic      [DATA_W-1:0]   dq_out,
   output logic                     dq_oe,
   input  wire logic                write_mask,
   output logic                     read_data_clk,
   output logic                     read_valid_flag,
   // Termination controls
   output logic                     dq_term_on,
   output logic                     write_mask_term_on,
   // Register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic      [31:0]         reg_rdata
);

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic [4:0] read_latency(input logic [2:0] cfg, input logic mux);
      logic [4:0] rl;
      rl = RL_CFG0;
      case (cfg)
         3'h2: rl = RL_CFG2;
         3'h3: rl = RL_CFG3;
         3'h4: rl = RL_CFG4;
         3'h5: rl = RL_CFG5;
         default: rl = RL_CFG0;
      endcase
      if (mux) begin
         rl = rl + MUX_EXTRA;
      end
      return rl;
   endfunction

   function automatic logic [3:0] burst_items(input logic [1:0] code);
      logic [3:0] n;
      n = 4'h2;
      if (code == BL_4) begin
         n = 4'h4;
      end else if (code == BL_8) begin
         n = 4'h8;
      end
      return n;
   endfunction

   // Unused ball positions per width and burst are forced to zero.
   function automatic logic [ADDR_W-1:0] rebuild(input logic [MUX_W-1:0] fh,
                                                 input logic [MUX_W-1:0] sh,
                                                 input logic [1:0]       wid,
                                                 input logic [1:0]       bl);
      logic [ADDR_W-1:0] a;
      a = '0;
      a[0]  = fh[0];
      a[3]  = fh[1];
      a[4]  = fh[2];
      a[5]  = fh[3];
      a[8]  = fh[4];
      a[9]  = fh[5];
      a[10] = fh[6];
      a[13] = fh[7];
      a[14] = fh[8];
      a[17] = fh[9];
      a[18] = fh[10];
      a[1]  = sh[1];
      a[2]  = sh[2];
      a[6]  = sh[4];
      a[7]  = sh[5];
      a[11] = sh[7];
      a[12] = sh[8];
      a[16] = sh[9];
      a[15] = sh[10];
      if (wid != WID_36 && bl != BL_8) begin
         a[19] = sh[6];
      end
      if (wid == WID_9 && bl == BL_2) begin
         a[20] = sh[0];
      end
      if ((wid == WID_36 && bl != BL_2) || (wid == WID_18 && bl == BL_8)) begin
         a[18] = 1'b0;
      end
      if (wid == WID_36 && bl == BL_8) begin
         a[17] = 1'b0;
      end
      return a;
   endfunction

   // ************************************************************
   // Pin sampling
   // ************************************************************
   // A third stage is needed so a level only counts once two stages agree.
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   logic [PIN_W-1:0] pin_s3;
   logic [PIN_W-1:0] pin_lvl;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_agree;
   logic [PIN_W-1:0] next_pin_lvl;

   assign pin_raw = {in_clk, sel_n, wr_strobe_n, ref_strobe_n, bank_addr, addr,
                     write_data_clk, dq_in, write_mask};
   assign pin_agree    = ~(pin_s2 ^ pin_s3);
   assign next_pin_lvl = (pin_s3 & pin_agree) | (pin_lvl & ~pin_agree);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_s1  <= '0;
         pin_s2  <= '0;
         pin_s3  <= '0;
         pin_lvl <= '0;
      end else begin
         pin_s1  <= pin_raw;
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         pin_lvl <= next_pin_lvl;
      end
   end

   logic               ck_now;
   logic               ck_rise;
   logic               ck_edge;
   logic               cmd_sel_n;
   logic               cmd_we_n;
   logic               cmd_ref_n;
   logic [BANK_W-1:0]  cmd_bank;
   logic [ADDR_W-1:0]  cmd_addr;
   logic               wdclk_edge;
   logic [DATA_W-1:0]  wr_data;
   logic               wr_mask;

   assign ck_now     = next_pin_lvl[47];
   assign ck_edge    = next_pin_lvl[47] ^ pin_lvl[47];
   assign ck_rise    = ck_edge & ck_now;
   assign cmd_sel_n  = next_pin_lvl[46];
   assign cmd_we_n   = next_pin_lvl[45];
   assign cmd_ref_n  = next_pin_lvl[44];
   assign cmd_bank   = next_pin_lvl[43:41];
   assign cmd_addr   = next_pin_lvl[40:20];
   assign wdclk_edge = next_pin_lvl[19] ^ pin_lvl[19];
   assign wr_data    = next_pin_lvl[18:1];
   assign wr_mask    = next_pin_lvl[0];

   // ************************************************************
   // Configuration register
   // ************************************************************
   logic [8:0] ctrl;
   logic       mux_mode;
   logic [2:0] lat_cfg;
   logic [1:0] bl_code;
   logic [1:0] wid_code;
   logic       term_en;

   assign mux_mode = ctrl[CTRL_MUX_BIT];
   assign lat_cfg  = ctrl[CTRL_LAT_LSB +: 3];
   assign bl_code  = ctrl[CTRL_BL_LSB +: 2];
   assign wid_code = ctrl[CTRL_WIDTH_LSB +: 2];
   assign term_en  = ctrl[CTRL_TERM_BIT];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (reg_write && reg_addr == CTRL_OFS) begin
         ctrl <= reg_wdata[8:0];
      end
   end

   // ************************************************************
   // Command decode
   // ************************************************************
   logic [4:0]   rl_now;
   logic [4:0]   wl_now;
   logic [3:0]   n_items;
   logic         second_due;
   logic         second_is_read;
   logic [IDX_W-1:0] pend_base;
   logic [MUX_W-1:0] pend_first;
   logic         is_read;
   logic         is_write;
   logic         is_refresh;
   logic         push_rd;
   logic         push_wr;
   logic [IDX_W-1:0] push_idx;
   logic [ADDR_W-1:0] full_addr;
   logic [SCHED_W-1:0] burst_mask;
   logic [7:0]   ref_count;

   assign rl_now  = read_latency(lat_cfg, mux_mode);
   assign wl_now  = rl_now + WL_EXTRA;
   assign n_items = burst_items(bl_code);
   // The second-half edge is never decoded as a command.
   assign is_read    = ck_rise && !second_due && !cmd_sel_n && cmd_we_n && cmd_ref_n;
   assign is_write   = ck_rise && !second_due && !cmd_sel_n && !cmd_we_n && cmd_ref_n;
   assign is_refresh = ck_rise && !second_due && !cmd_sel_n && cmd_we_n && !cmd_ref_n;
   assign full_addr  = rebuild(pend_first, cmd_addr[MUX_W-1:0], wid_code, bl_code);
   assign push_rd    = mux_mode ? (ck_rise && second_due && second_is_read) : is_read;
   assign push_wr    = mux_mode ? (ck_rise && second_due && !second_is_read) : is_write;
   // Non-multiplexed: address and bank arrive with the command.
   assign push_idx   = mux_mode ? {pend_base[4], full_addr[3:0]} : {cmd_bank[0], cmd_addr[3:0]};
   assign burst_mask = SCHED_W'((32'h1 << n_items) - 32'h1);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         second_due     <= 1'b0;
         second_is_read <= 1'b0;
         pend_base      <= '0;
         pend_first     <= '0;
      end else if (ck_rise) begin
         second_due     <= mux_mode && (is_read || is_write);
         second_is_read <= is_read;
         pend_base      <= {cmd_bank[0], 4'h0};
         pend_first     <= cmd_addr[MUX_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ref_count <= 8'h00;
      end else if (is_refresh) begin
         ref_count <= ref_count + 8'h01;
      end
   end

   // ************************************************************
   // Half-cycle schedules
   // ************************************************************
   // Each bit is one input-clock half cycle; bit zero is the current one.
   // Idle commands add nothing but never clear what is queued.
   logic [SCHED_W-1:0] rd_sched;
   logic [SCHED_W-1:0] wr_sched;
   logic [SCHED_W-1:0] next_rd_sched;
   logic [SCHED_W-1:0] next_wr_sched;

   always_comb begin
      next_rd_sched = rd_sched >> 1;
      next_wr_sched = wr_sched >> 1;
      if (is_read) begin
         next_rd_sched = next_rd_sched | (burst_mask << {rl_now, 1'b0});
      end
      if (is_write) begin
         next_wr_sched = next_wr_sched | (burst_mask << {wl_now, 1'b0});
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_sched <= '0;
         wr_sched <= '0;
      end else if (ck_edge) begin
         rd_sched <= next_rd_sched;
         wr_sched <= next_wr_sched;
      end
   end

   // ************************************************************
   // Address queues and storage
   // ************************************************************
   logic [IDX_W-1:0]  rd_q [4];
   logic [IDX_W-1:0]  wr_q [4];
   logic [QPTR_W-1:0] rd_wp;
   logic [QPTR_W-1:0] rd_rp;
   logic [QPTR_W-1:0] wr_wp;
   logic [QPTR_W-1:0] wr_rp;
   logic [3:0]        rd_item;
   logic [3:0]        wr_item;
   logic [DATA_W-1:0] mem [MEM_D];
   logic              rd_step;
   logic              wr_step;
   logic [IDX_W-1:0]  rd_idx;
   logic [IDX_W-1:0]  wr_idx;

   assign rd_step = ck_edge && next_rd_sched[0];
   assign wr_step = wdclk_edge && wr_sched[0];
   assign rd_idx  = rd_q[rd_rp] + IDX_W'(rd_item);
   assign wr_idx  = wr_q[wr_rp] + IDX_W'(wr_item);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_wp <= '0;
         wr_wp <= '0;
      end else begin
         if (push_rd) begin
            rd_q[rd_wp] <= push_idx;
            rd_wp       <= rd_wp + 2'h1;
         end
         if (push_wr) begin
            wr_q[wr_wp] <= push_idx;
            wr_wp       <= wr_wp + 2'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_rp   <= '0;
         rd_item <= 4'h0;
      end else if (rd_step) begin
         if (rd_item == n_items - 4'h1) begin
            rd_item <= 4'h0;
            rd_rp   <= rd_rp + 2'h1;
         end else begin
            rd_item <= rd_item + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_rp   <= '0;
         wr_item <= 4'h0;
      end else if (wr_step) begin
         if (wr_item == n_items - 4'h1) begin
            wr_item <= 4'h0;
            wr_rp   <= wr_rp + 2'h1;
         end else begin
            wr_item <= wr_item + 4'h1;
         end
      end
   end

   // Storage has no reset, as a real array would not.
   always_ff @(posedge clock) begin
      if (wr_step && !wr_mask) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // ************************************************************
   // Read data path
   // ************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dq_out          <= '0;
         dq_oe           <= 1'b0;
         read_valid_flag <= 1'b0;
      end else if (ck_edge) begin
         dq_out          <= next_rd_sched[0] ? mem[rd_idx] : '0;
         dq_oe           <= next_rd_sched[0];
         // Valid looks one half cycle ahead, so it rises early and drops on the last item.
         // With no edges it simply holds, which keeps it high if the clock stalls.
         read_valid_flag <= next_rd_sched[1];
      end
   end

   // The read clock follows the input clock in the same cycle as the data.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         read_data_clk <= 1'b0;
      end else begin
         read_data_clk <= ck_now;
      end
   end

   // ************************************************************
   // Termination
   // ************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dq_term_on         <= 1'b0;
         write_mask_term_on <= 1'b0;
      end else begin
         dq_term_on         <= term_en && !(ck_edge ? next_rd_sched[0] : dq_oe);
         write_mask_term_on <= term_en;
      end
   end

   // ************************************************************
   // Register read port
   // ************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         if (reg_addr == CTRL_OFS) begin
            reg_rdata <= {23'h0, ctrl};
         end else if (reg_addr == STATUS_OFS) begin
            reg_rdata <= {16'h0, ref_count, 5'h0, (wr_sched != '0), dq_oe, read_valid_flag};
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// File: rtl/lldcp_pkg.sv
// Purpose: Shared constants for the low-latency DRAM command port.
// Assumes: Byte-addressed register port with 32-bit words.
// Notes:   Widths are fixed; data path is the 18-bit organisation.

package lldcp_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W   = 21;
   localparam int MUX_W    = 11;
   localparam int BANK_W   = 3;
   localparam int DATA_W   = 18;
   localparam int IDX_W    = 5;
   localparam int MEM_D    = 32;
   localparam int SCHED_W  = 32;
   localparam int QPTR_W   = 2;
   localparam int PIN_W    = 48;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  STATUS_OFS      = 8'h04;
   localparam int          CTRL_MUX_BIT    = 0;
   localparam int          CTRL_LAT_LSB    = 1;
   localparam int          CTRL_BL_LSB     = 4;
   localparam int          CTRL_WIDTH_LSB  = 6;
   localparam int          CTRL_TERM_BIT   = 8;
   localparam logic [8:0]  CTRL_RESET      = 9'h000;
   localparam int          STAT_VALID_BIT  = 0;
   localparam int          STAT_DRIVE_BIT  = 1;
   localparam int          STAT_WRWIN_BIT  = 2;
   localparam int          STAT_REF_LSB    = 8;

   // ************************************************************
   // Burst length and data width codes
   // ************************************************************
   localparam logic [1:0]  BL_2   = 2'h0;
   localparam logic [1:0]  BL_4   = 2'h1;
   localparam logic [1:0]  BL_8   = 2'h2;
   localparam logic [1:0]  WID_9  = 2'h0;
   localparam logic [1:0]  WID_18 = 2'h1;
   localparam logic [1:0]  WID_36 = 2'h2;

   // ************************************************************
   // Read latency per configuration, in input-clock cycles
   // ************************************************************
   localparam logic [4:0]  RL_CFG0 = 5'h05;
   localparam logic [4:0]  RL_CFG2 = 5'h07;
   localparam logic [4:0]  RL_CFG3 = 5'h09;
   localparam logic [4:0]  RL_CFG4 = 5'h04;
   localparam logic [4:0]  RL_CFG5 = 5'h06;
   localparam logic [4:0]  MUX_EXTRA = 5'h01;
   localparam logic [4:0]  WL_EXTRA  = 5'h01;

endpackage

// File: sim/lldcp_core_bench.sv
// Purpose: Self-checking bench for the DRAM command port.
// Assumes: Control register at reset is zero; latency configuration 0.
// Notes:   Pins are judged 30 ns after each input clock edge.
`timescale 1ns/100ps
`default_nettype none
module lldcp_core_bench
   import lldcp_pkg::*;
;
   logic              clock, rst_n, reg_write, reg_read;
   logic [7:0]        reg_addr;
   logic [31:0]       reg_wdata, reg_rdata, rd_val;
   logic              in_clk, sel_n, wr_strobe_n, ref_strobe_n, write_data_clk, write_mask;
   logic [BANK_W-1:0] bank_addr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic              dq_oe, read_data_clk, read_valid_flag, dq_term_on, write_mask_term_on;
   int                err_total = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   lldcp_core uut (.clock, .rst_n, .in_clk, .sel_n, .wr_strobe_n, .ref_strobe_n, .bank_addr, .addr,
      .write_data_clk, .dq_in, .dq_out, .dq_oe, .write_mask, .read_data_clk, .read_valid_flag,
      .dq_term_on, .write_mask_term_on, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
   lldcp_ctrl_model ctrl (.in_clk, .sel_n, .wr_strobe_n, .ref_strobe_n, .bank_addr, .addr,
      .write_data_clk, .dq_in, .write_mask);
   task automatic summarize();
      $display("Checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task automatic wr(input logic [DATA_W-1:0] d0, d1, input logic m1);
      fork
         begin
            ctrl.cmd(3'b001, 3'h0, 21'h6);
            ctrl.idle();
         end
         ctrl.burst(6, d0, d1, m1);
      join
      repeat (2) @(posedge in_clk);
   endtask
   // One idle cycle always follows the read commands, so a write may come next.
   task automatic rd(input int n, input logic mux, input int rl, input logic stop,
                     input logic [DATA_W-1:0] e0, e1);
      fork
         begin
            for (int i = 0; i < n; i++) begin
               ctrl.cmd(3'b011, 3'h0, mux ? 21'h0 : 21'h6);
               if (mux) ctrl.cmd(3'b111, 3'h0, 21'h6);
            end
            ctrl.idle();
         end
      join_none
      @(negedge in_clk);
      @(posedge in_clk);
      repeat (2 * rl - 1) @(in_clk);
      #30;
      chk("valid_lead", 1'b1, read_valid_flag);
      chk("oe_early", 1'b0, dq_oe);
      if (stop) begin
         ctrl.run = 1'b0;
         repeat (20) @(posedge clock);
         chk("valid_hold", 1'b1, read_valid_flag);
         ctrl.run = 1'b1;
      end
      for (int k = 0; k < 2 * n; k++) begin
         @(in_clk);
         #30;
         chk("oe", 1'b1, dq_oe);
         chk("data", k % 2 ? e1 : e0, dq_out);
         chk("valid", k < 2 * n - 1, read_valid_flag);
      end
      @(in_clk);
      #30;
      chk("oe_off", 1'b0, dq_oe);
      chk("term_on", 1'b1, dq_term_on);
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      rst_n = 1'b0;
      {reg_write, reg_read} = 2'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rreg(CTRL_OFS);
      chk("ctrl_reset", 18'h00000, rd_val[17:0]);
      wreg(CTRL_OFS, 32'h00000140);
      wreg(STATUS_OFS, 32'hFFFFFFFF);
      rreg(CTRL_OFS);
      chk("ctrl", 18'h00140, rd_val[17:0]);
      rreg(STATUS_OFS);
      chk("status", 18'h00000, rd_val[17:0]);
      rreg(8'h08);
      chk("unmapped", 18'h00000, rd_val[17:0]);
      chk("mask_term", 1'b1, write_mask_term_on);
      wr(18'h2A5A5, 18'h15A5A, 1'b0);
      wr(18'h0F0F0, 18'h30F0F, 1'b1);
      rd(2, 1'b0, 5, 1'b0, 18'h0F0F0, 18'h15A5A);
      rd(1, 1'b0, 5, 1'b1, 18'h0F0F0, 18'h15A5A);
      wreg(CTRL_OFS, 32'h00000141);
      rd(1, 1'b1, 6, 1'b0, 18'h0F0F0, 18'h15A5A);
      repeat (3) ctrl.cmd(3'b010, 3'h1, 21'h0);
      ctrl.idle();
      repeat (8) @(posedge clock);
      rreg(STATUS_OFS);
      chk("refresh_count", 18'h00003, {10'h000, rd_val[15:8]});
      summarize();
   end
endmodule
bind lldcp_core lldcp_core_chk chk_i (.clock, .rst_n, .in_clk, .dq_out, .dq_oe, .read_data_clk,
   .read_valid_flag, .dq_term_on, .write_mask_term_on, .reg_addr, .reg_wdata, .reg_write);
`default_nettype wire

// File: sim/lldcp_core_chk.sv
// Purpose: Port checks for the DRAM command port.
// Assumes: Bound to lldcp_core; half an input clock is about six clocks.
// Notes:   Termination enable is tracked from control register writes.
`timescale 1ns/100ps
`default_nettype none
module lldcp_core_chk
   import lldcp_pkg::*;
(
   // Clock and reset
   input wire logic              clock,
   input wire logic              rst_n,
   // Pins
   input wire logic              in_clk,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe,
   input wire logic              read_data_clk,
   input wire logic              read_valid_flag,
   input wire logic              dq_term_on,
   input wire logic              write_mask_term_on,
   // Register port
   input wire logic [7:0]        reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_write
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic       term_en;
   logic [1:0] quiet;
   // The settle count lets the enable pass the control register first.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         term_en <= 1'b0;
         quiet   <= 2'h0;
      end else if (reg_write && reg_addr == CTRL_OFS) begin
         term_en <= reg_wdata[CTRL_TERM_BIT];
         quiet   <= 2'h0;
      end else if (quiet != 2'h3) begin
         quiet <= quiet + 2'h1;
      end
   end
   sequence s_last_item;
      dq_oe [*4];
   endsequence
   property p_mask_term;
      quiet == 2'h3 |-> write_mask_term_on == term_en;
   endproperty
   property p_term_off;
      dq_oe |-> !dq_term_on;
   endproperty
   property p_term_gated;
      dq_term_on |-> write_mask_term_on;
   endproperty
   property p_term_back;
      $fell(dq_oe) && term_en |-> ##[0:1] dq_term_on;
   endproperty
   property p_valid_lead;
      $rose(dq_oe) |-> read_valid_flag && $past(read_valid_flag, 4);
   endproperty
   property p_valid_fall;
      $fell(read_valid_flag) |-> s_last_item ##[1:8] !dq_oe;
   endproperty
   property p_rdclk;
      $changed(in_clk) |-> ##[1:5] read_data_clk == in_clk;
   endproperty
   property p_hold_stop;
      $stable(in_clk) [*8] |-> $stable(read_valid_flag) && $stable(dq_oe);
   endproperty
   property p_dq_idle;
      !dq_oe |-> dq_out == '0;
   endproperty
   a_mask_term: assert property (p_mask_term) else $error("mask termination wrong");
   a_term_off: assert property (p_term_off) else $error("termination on while driving");
   a_term_gated: assert property (p_term_gated) else $error("data termination without enable");
   a_term_back: assert property (p_term_back) else $error("termination not restored");
   a_valid_lead: assert property (p_valid_lead) else $error("valid flag late");
   a_valid_fall: assert property (p_valid_fall) else $error("valid fell off last item");
   a_rdclk: assert property (p_rdclk) else $error("read data clock stalled");
   a_hold_stop: assert property (p_hold_stop) else $error("output moved without clock");
   a_dq_idle: assert property (p_dq_idle) else $error("data driven while released");
endmodule
`default_nettype wire

// File: sim/lldcp_ctrl_model.sv
// Purpose: Behavioural external memory controller for the command port.
// Assumes: Input clock period 64 ns; pins change on the clock edges.
// Notes:   Released pins show inverted values so stale data cannot pass.
`timescale 1ns/100ps
`default_nettype none
module lldcp_ctrl_model
   import lldcp_pkg::*;
(
   // Command side
   output logic              in_clk,
   output logic              sel_n,
   output logic              wr_strobe_n,
   output logic              ref_strobe_n,
   output logic [BANK_W-1:0] bank_addr,
   output logic [ADDR_W-1:0] addr,
   // Write data side
   output logic              write_data_clk,
   output logic [DATA_W-1:0] dq_in,
   output logic              write_mask
);
   logic run = 1'b1;
   initial begin
      {in_clk, write_data_clk, write_mask} = 3'h0;
      {sel_n, wr_strobe_n, ref_strobe_n} = 3'h7;
      bank_addr = '0;
      addr = '0;
      dq_in = '0;
   end
   // Clearing run freezes the input clock to model a lost clock.
   always #32 if (run) in_clk = ~in_clk;
   // Quarter-cycle offset centres each data item on its capture edge.
   always @(in_clk) write_data_clk <= #16 in_clk;
   // Command c is {select, write strobe, refresh strobe}, all active low.
   task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [20:0] a);
      @(negedge in_clk);
      {sel_n, wr_strobe_n, ref_strobe_n} = c;
      bank_addr = b;
      addr = a;
      // Pins hold past the sampling edge, since the device only sees them after it.
      @(posedge in_clk);
   endtask
   // Deselect ends a command sequence; address and bank show their inverse.
   task automatic idle();
      @(negedge in_clk);
      sel_n = 1'b1;
      bank_addr = ~bank_addr;
      addr = ~addr;
   endtask
   task automatic burst(input int wl, input logic [DATA_W-1:0] d0, d1, input logic m1);
      @(negedge in_clk);
      @(posedge in_clk);
      repeat (2 * wl) @(in_clk);
      dq_in = d0;
      write_mask = 1'b0;
      @(in_clk);
      dq_in = d1;
      write_mask = m1;
      @(in_clk);
      dq_in = ~d1;
      write_mask = ~m1;
   endtask
endmodule
`default_nettype wire
